// ==== src/dac_regs_pkg.sv ====
// Package for the DAC configuration and clear-value register bank.
// Assumes a 24-bit serial frame, MSB first, shifted in on sclk edges.
`default_nettype none
package dac_regs_pkg;
    // Frame layout
    localparam int          FRAME_BITS      = 24;
    localparam int          RW_POS          = 23;
    localparam int          ADDR_HI         = 22;
    localparam int          ADDR_LO         = 20;
    localparam int          DATA_BITS       = 20;
    localparam logic        RW_WRITE        = 1'b0;
    localparam logic        RW_READ         = 1'b1;
    // Register addresses
    localparam logic [2:0]  ADDR_DAC        = 3'h1;
    localparam logic [2:0]  ADDR_CONTROL    = 3'h2;
    localparam logic [2:0]  ADDR_CLEAR_VAL  = 3'h3;
    localparam logic [2:0]  ADDR_SOFT_CTRL  = 3'h4;
    // Control register field positions
    localparam int          CODING_POS      = 4;
    localparam int          SDO_DIS_POS     = 5;
    localparam int          LIN_COMP_LO     = 6;
    localparam int          LIN_COMP_HI     = 9;
    // Software control field position
    localparam int          SOFT_CLEAR_POS  = 1;
    // Reset values
    localparam logic [19:0] CLEAR_VAL_RESET = 20'h00000;
    localparam logic [19:0] DAC_RESET       = 20'h00000;
    localparam logic [3:0]  LIN_COMP_RESET  = 4'h0;
    localparam logic        CODING_RESET    = 1'b0;
    localparam logic        SDO_DIS_RESET   = 1'b0;
endpackage
`default_nettype wire

// ==== src/serial_shifter.sv ====
// Serial frame shifter: captures 24-bit frames, shifts read data out.
// Assumes sclk and sync_n are synchronous inputs sampled on clock_in.
`default_nettype none
module serial_shifter
    import dac_regs_pkg::*;
#(
    parameter int WIDTH = FRAME_BITS  // Frame length in bits
)(
    input  wire logic             clock_in,    // System clock
    input  wire logic             resetn_in,   // Sync reset, active low
    input  wire logic             sclk_in,     // Serial clock (sampled)
    input  wire logic             sync_n_in,   // Frame select, active low
    input  wire logic             sdin_in,     // Serial data in
    input  wire logic             load_in,     // Load readback word
    input  wire logic [WIDTH-1:0] load_word_in,// Readback word
    output logic                  frame_out,   // Pulse: frame complete
    output logic      [WIDTH-1:0] word_out,    // Captured frame
    output logic                  sdo_out      // Serial data out
);
    // Refuse a frame length the bit counter and decode cannot serve
    if (WIDTH != FRAME_BITS)
    begin
        $error("serial_shifter: WIDTH must equal frame length");
    end

    logic             sclk_q;     // Previous serial clock
    logic [WIDTH-1:0] shift_q;    // Input shift register
    logic [WIDTH-1:0] out_q;      // Output shift register
    logic [4:0]       count_q;    // Bits received in frame

    wire rise = sclk_in & ~sclk_q;   // Sample edge
    wire fall = ~sclk_in & sclk_q;   // Launch edge
    wire last = (count_q == 5'(WIDTH - 1));

    // Shift in on rising edge, out on falling edge, frame by sync_n
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            sclk_q    <= 1'b0;
            shift_q   <= '0;
            out_q     <= '0;
            count_q   <= 5'h00;
            frame_out <= 1'b0;
        end
        else
        begin
            sclk_q    <= sclk_in;
            frame_out <= 1'b0;
            if (load_in)
                out_q <= load_word_in;
            else if (!sync_n_in && fall)
                out_q <= {out_q[WIDTH-2:0], 1'b0};
            if (sync_n_in)
                count_q <= 5'h00;  // Abandoned frames are dropped
            else if (rise)
            begin
                shift_q <= {shift_q[WIDTH-2:0], sdin_in};
                count_q <= last ? 5'h00 : count_q + 5'h01;
                frame_out <= last;
            end
        end
    end

    assign word_out = shift_q;
    assign sdo_out  = out_q[WIDTH-1];
endmodule
`default_nettype wire

// ==== src/dac_config_regs.sv ====
// DAC configuration and clear-value register bank with serial access.
// Assumes the host keeps the frame format and uses listed codes only.
`default_nettype none
module dac_config_regs
    import dac_regs_pkg::*;
#(
    parameter int DWIDTH = DATA_BITS  // DAC data width
)(
    input  wire logic              clock_in,      // System clock 25 MHz
    input  wire logic              resetn_in,     // Sync reset, active low
    input  wire logic              sclk_in,       // Serial clock
    input  wire logic              sync_n_in,     // Frame select, low
    input  wire logic              sdin_in,       // Serial data in
    input  wire logic              clear_strobe_n_in, // Clear pin, low
    output logic                   sdo_out,       // Serial data out
    output logic                   sdo_oe_out,    // SDO drive enable
    output logic      [DWIDTH-1:0] dac_code_out,  // Straight binary code
    output logic                   coding_select_out, // Current coding
    output logic      [3:0]        lin_comp_out   // Linearity field
);
    // Refuse widths the frame decode cannot serve
    if (DWIDTH != DATA_BITS)
    begin
        $error("dac_config_regs: DWIDTH must be 20");
    end

    ////////////////////////////////////////////////////////////////////
    // Serial front end

    logic                  frame;      // Frame complete pulse
    logic [FRAME_BITS-1:0] word;       // Captured frame
    logic                  sdo_raw;    // Shifter output bit
    logic                  load_q;     // Load readback word
    logic [FRAME_BITS-1:0] rdata_q;    // Readback word

    serial_shifter #(.WIDTH(FRAME_BITS)) shifter_u (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .sclk_in      (sclk_in),
        .sync_n_in    (sync_n_in),
        .sdin_in      (sdin_in),
        .load_in      (load_q),
        .load_word_in (rdata_q),
        .frame_out    (frame),
        .word_out     (word),
        .sdo_out      (sdo_raw)
    );

    ////////////////////////////////////////////////////////////////////
    // Frame decode

    wire [2:0]        addr   = word[ADDR_HI:ADDR_LO];
    wire [DWIDTH-1:0] data   = word[DWIDTH-1:0];
    wire              is_rd  = word[RW_POS] == RW_READ;
    wire              is_wr  = word[RW_POS] == RW_WRITE;
    wire              wr     = frame && is_wr;
    wire              rd     = frame && is_rd;
    wire wr_dac   = wr && addr == ADDR_DAC;
    wire wr_ctrl  = wr && addr == ADDR_CONTROL;
    wire wr_clear = wr && addr == ADDR_CLEAR_VAL;
    wire soft_clr = wr && addr == ADDR_SOFT_CTRL && data[SOFT_CLEAR_POS];
    wire clear_req = !clear_strobe_n_in || soft_clr;

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [DWIDTH-1:0] dac_q;        // DAC register
    logic [DWIDTH-1:0] clear_val_q;  // Clear-value register
    logic              coding_q;     // 0 twos complement, 1 offset bin
    logic              sdo_dis_q;    // Serial output disable
    logic [3:0]        lin_comp_q;   // Linearity compensation

    // Convert a register code to straight binary for the converter
    function automatic logic [DWIDTH-1:0] to_binary(
        input logic [DWIDTH-1:0] code,
        input logic              offset_bin
    );
        // Twos complement: flip the sign bit to get offset binary
        to_binary = offset_bin ? code
                  : {~code[DWIDTH-1], code[DWIDTH-2:0]};
    endfunction

    // Readback word by address; unmapped addresses read zero
    wire [19:0] ctrl_rd = {10'h000, lin_comp_q, sdo_dis_q, coding_q,
                           4'h0};
    wire [19:0] rd_mux  = addr == ADDR_DAC       ? dac_q :
                          addr == ADDR_CONTROL   ? ctrl_rd :
                          addr == ADDR_CLEAR_VAL ? clear_val_q : 20'h00000;

    // Register writes; clear takes priority over a DAC write
    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            dac_q       <= DAC_RESET;
            clear_val_q <= CLEAR_VAL_RESET;
            coding_q    <= CODING_RESET;
            sdo_dis_q   <= SDO_DIS_RESET;
            lin_comp_q  <= LIN_COMP_RESET;
            load_q      <= 1'b0;
            rdata_q     <= '0;
        end
        else
        begin
            load_q <= rd;
            if (rd)
                rdata_q <= {word[RW_POS:ADDR_LO], rd_mux};
            if (wr_clear)
                clear_val_q <= data;
            if (wr_ctrl)
            begin
                coding_q   <= data[CODING_POS];
                sdo_dis_q  <= data[SDO_DIS_POS];
                lin_comp_q <= data[LIN_COMP_HI:LIN_COMP_LO];
            end
            if (clear_req)
                dac_q <= clear_val_q;
            else if (wr_dac)
                dac_q <= data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all registered

    always_ff @(posedge clock_in)
    begin
        if (!resetn_in)
        begin
            dac_code_out      <= '0;
            coding_select_out <= CODING_RESET;
            lin_comp_out      <= LIN_COMP_RESET;
            sdo_out           <= 1'b0;
            sdo_oe_out        <= 1'b0;
        end
        else
        begin
            // Clear value decoded with the current coding
            dac_code_out      <= clear_req
                               ? to_binary(clear_val_q, coding_q)
                               : to_binary(dac_q, coding_q);
            coding_select_out <= coding_q;
            lin_comp_out      <= lin_comp_q;
            sdo_out           <= sdo_raw;
            sdo_oe_out        <= !sdo_dis_q && !sync_n_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    clear_loads_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) clear_req |=> dac_q == $past(clear_val_q))
        else $error("clear did not load clear value");
    clear_out_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) clear_req && coding_q |=>
        dac_code_out == $past(clear_val_q))
        else $error("clear output not immediate");
    twos_comp_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !clear_req && !coding_q |=>
        dac_code_out == {~$past(dac_q[19]), $past(dac_q[18:0])})
        else $error("twos complement decode wrong");
    offset_bin_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !clear_req && coding_q |=>
        dac_code_out == $past(dac_q))
        else $error("offset binary decode wrong");
    clear_coding_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) clear_req && !coding_q |=>
        dac_code_out[19] == !$past(clear_val_q[19]))
        else $error("clear value coding wrong");
    sdo_tristate_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) sdo_dis_q |=> !sdo_oe_out)
        else $error("sdo driven while disabled");
    reset_vals_a: assert property (@(posedge clock_in)
        !resetn_in |=> clear_val_q == 20'h00000 && lin_comp_q == 4'h0)
        else $error("reset values wrong");
    lin_reset_a: assert property (@(posedge clock_in)
        $rose(resetn_in) |-> lin_comp_out == 4'h0)
        else $error("linearity field not zero after reset");
    clear_write_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) wr_clear |=> clear_val_q == $past(data))
        else $error("clear value write lost");
    read_nowrite_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) rd |=> $stable(clear_val_q))
        else $error("read frame altered register");

    // Register write paths; a clear in the same cycle wins the DAC
    // register, so the DAC write check steps aside for it
    dac_write_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) wr_dac && !clear_req |=>
        dac_q == $past(data))
        else $error("dac register write lost");
    coding_write_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) wr_ctrl |=>
        coding_q == $past(data[CODING_POS]))
        else $error("coding select write lost");
    lin_write_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) wr_ctrl |=>
        lin_comp_q == $past(data[LIN_COMP_HI:LIN_COMP_LO]))
        else $error("linearity field write lost");

    // Serial pin and readback path
    sdo_drive_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !sdo_dis_q && !sync_n_in |=> sdo_oe_out)
        else $error("sdo not driven while enabled");
    read_load_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) rd |=> load_q)
        else $error("read frame did not load readback");
    write_noload_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) wr |=> !load_q)
        else $error("write frame loaded readback");
    read_zero_a: assert property (@(posedge clock_in)
        disable iff (!resetn_in) rd && addr == 3'h0 |=> rdata_q[19:0] == '0)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ==== bench/serial_host.sv ====
// Host model: sends 24-bit serial frames and captures the read wire.
// Assumes the device samples sclk on clock_in, two clocks per phase.
`default_nettype none
module serial_host (
    input  wire logic clock_in,   // Bench clock
    input  wire logic sdo_in,     // Resolved serial data wire
    input  wire logic sdo_oe_in,  // Device drive enable
    output logic      sclk_out,   // Serial clock, idle low
    output logic      sync_n_out, // Frame select, active low
    output logic      sdin_out    // Serial data to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] rx_word; // Bits seen on the read wire
    logic        oe_seen; // Device drove the wire in this frame
    event        got;     // Captured word is ready
    initial
    begin
        sclk_out = 1'b0;
        sync_n_out = 1'b1;
        sdin_out = 1'b0;
    end
    // Two clocks per phase, so no sclk edge slips past the sampler
    task automatic frame(input logic [23:0] w, input bit grab);
        oe_seen = 1'b0;
        @(negedge clock_in);
        sync_n_out = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            sdin_out = w[i];
            repeat (2) @(negedge clock_in);
            rx_word[i] = sdo_in;
            oe_seen = oe_seen | sdo_oe_in;
            sclk_out = 1'b1;
            repeat (2) @(negedge clock_in);
            sclk_out = 1'b0;
        end
        repeat (2) @(negedge clock_in);
        sync_n_out = 1'b1;
        // Data line no longer held: show a changed level
        sdin_out = ~sdin_out;
        if (grab)
            -> got;
    endtask
endmodule
`default_nettype wire

// ==== bench/dac_config_regs_tb.sv ====
// Testbench for the register bank, driven through the serial host model.
// Assumes read data shows in the frame that follows the read request.
`default_nettype none
module dac_config_regs_tb
    import dac_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in;          // 25 MHz clock
    logic        resetn_in;         // Reset, active low
    logic        clear_strobe_n_in; // Clear pin, active low
    wire         sclk;              // Serial clock from host
    wire         sync_n;            // Frame select from host
    wire         sdin;              // Serial data from host
    logic        sdo;               // Device data out
    logic        sdo_oe;            // Device drive enable
    logic        coding;            // Coding select seen
    logic [19:0] dac_code;          // Converter code seen
    logic [3:0]  lin;               // Linearity field seen
    logic        sdo_last = 1'b0;   // Last level on the read wire
    logic [23:0] exp_q[$];          // Expected read words
    logic [23:0] mask_q[$];         // Bits that matter in them
    int          miscompares = 0;   // Mismatch count
    int          checks_done = 0;   // Comparison count
    // Undriven wire must not hold a value the sim could pick for us
    wire         sdo_wire = sdo_oe ? sdo : ~sdo_last;
    always @(posedge clock_in)
        sdo_last <= sdo_wire;
    dac_config_regs dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .sclk_in(sclk), .sync_n_in(sync_n), .sdin_in(sdin),
        .clear_strobe_n_in(clear_strobe_n_in), .sdo_out(sdo),
        .sdo_oe_out(sdo_oe), .dac_code_out(dac_code),
        .coding_select_out(coding), .lin_comp_out(lin));
    serial_host host (.clock_in(clock_in), .sdo_in(sdo_wire),
        .sdo_oe_in(sdo_oe), .sclk_out(sclk), .sync_n_out(sync_n),
        .sdin_out(sdin));
    ////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Register write frame
    task automatic wr(input logic [2:0] a, input logic [19:0] d);
        host.frame({RW_WRITE, a, d}, 1'b0);
    endtask
    // Read frame, then a harmless frame that carries the answer out
    task automatic rd(input logic [2:0] a, input logic [19:0] e,
                      input logic [19:0] m);
        exp_q.push_back({4'h0, e & m});
        mask_q.push_back({4'h0, m});
        host.frame({RW_READ, a, 20'h0}, 1'b0);
        host.frame({RW_READ, 3'h0, 20'h0}, 1'b1);
    endtask
    // Output path takes two clocks; four leaves margin
    task automatic settle;
        repeat (4) @(negedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Clock, watcher and watchdog
    initial
    begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial
    forever
    begin
        @(host.got);
        check(host.rx_word & mask_q.pop_front(), exp_q.pop_front());
    end
    initial
    begin
        #500us;
        miscompares++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [19:0] v;
        logic [19:0] w;
        logic [19:0] u;
        resetn_in = 1'b0;
        clear_strobe_n_in = 1'b1;
        void'($urandom(98));
        repeat (6) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (2) @(negedge clock_in);
        check({23'h0, coding}, 24'h0);
        check({20'h0, lin}, 24'h0);
        check({23'h0, sdo_oe}, 24'h0);
        check({4'h0, dac_code}, 24'h80000);
        rd(ADDR_CLEAR_VAL, 20'h0, 20'hfffff);
        $display("test reset done");
        // Clear pin with twos complement coding
        v = 20'($urandom());
        wr(ADDR_CLEAR_VAL, v);
        rd(ADDR_CLEAR_VAL, v, 20'hfffff);
        check({23'h0, host.oe_seen}, 24'h1);
        clear_strobe_n_in = 1'b0;
        repeat (3) @(negedge clock_in);
        check({4'h0, dac_code}, {4'h0, v ^ 20'h80000});
        clear_strobe_n_in = 1'b1;
        // Offset binary, then the soft clear bit
        wr(ADDR_CONTROL, 20'h10);
        settle();
        check({23'h0, coding}, 24'h1);
        check({4'h0, dac_code}, {4'h0, v});
        w = 20'($urandom());
        wr(ADDR_CLEAR_VAL, w);
        wr(ADDR_SOFT_CTRL, 20'h2);
        settle();
        check({4'h0, dac_code}, {4'h0, w});
        $display("test clear done");
        // Every listed linearity code, back to back with readback
        for (int c = 9; c <= 12; c++)
        begin
            wr(ADDR_CONTROL, {10'h0, 4'(c), 6'h10});
            settle();
            check({20'h0, lin}, {20'h0, 4'(c)});
            rd(ADDR_CONTROL, {10'h0, 4'(c), 6'h10}, 20'h3f0);
        end
        $display("test linearity done");
        // Read pin disabled: never driven during a read frame
        wr(ADDR_CONTROL, 20'h20);
        host.frame({RW_READ, ADDR_CONTROL, 20'h0}, 1'b0);
        check({23'h0, host.oe_seen}, 24'h0);
        check({4'h0, dac_code}, {4'h0, w ^ 20'h80000});
        wr(ADDR_CONTROL, 20'h0);
        host.frame({RW_READ, ADDR_CONTROL, 20'h0}, 1'b0);
        check({23'h0, host.oe_seen}, 24'h1);
        $display("test read pin done");
        // DAC register write and readback, then an unmapped address
        u = 20'($urandom());
        wr(ADDR_DAC, u);
        settle();
        check({4'h0, dac_code}, {4'h0, u ^ 20'h80000});
        rd(ADDR_DAC, u, 20'hfffff);
        wr(3'h7, ~u);
        rd(3'h7, 20'h0, 20'hfffff);
        check({4'h0, dac_code}, {4'h0, u ^ 20'h80000});
        $display("test dac write done");
        // Mid-run reset must undo written registers
        wr(ADDR_CONTROL, 20'h310);
        settle();
        check({20'h0, lin}, 24'hc);
        resetn_in = 1'b0;
        repeat (6) @(negedge clock_in);
        resetn_in = 1'b1;
        repeat (2) @(negedge clock_in);
        check({20'h0, lin}, 24'h0);
        check({23'h0, coding}, 24'h0);
        check({4'h0, dac_code}, 24'h80000);
        rd(ADDR_CLEAR_VAL, 20'h0, 20'hfffff);
        rd(ADDR_CONTROL, 20'h0, 20'h3f0);
        $display("test mid reset done");
        stop_test();
    end
endmodule
`default_nettype wire
